/* File: src/sbc_pkg.sv */
// Purpose: Shared constants and types for the serial bus control/status block.
// Assumes: One 8-bit control/status register and one data register on a byte-wide SFR port.
// Notes: Timing counts are in link-clock cycles.
package sbc_pkg;

  // Register addresses, page and reset values.
  localparam logic [7:0] SBC_CTRL_ADDR  = 8'hC0;
  localparam logic [7:0] SBC_DATA_ADDR  = 8'hC2;
  localparam logic [7:0] SBC_SFR_PAGE   = 8'h00;
  localparam logic [7:0] SBC_CTRL_RESET = 8'h00;
  localparam logic [7:0] SBC_DATA_RESET = 8'h00;
  localparam logic [7:0] SBC_CTRL_WMASK = 8'h33;

  // Bit positions inside the control/status register.
  localparam int SBC_BIT_ROLE  = 7;
  localparam int SBC_BIT_TXIND = 6;
  localparam int SBC_BIT_BEGIN = 5;
  localparam int SBC_BIT_HALT  = 4;
  localparam int SBC_BIT_RESP  = 3;
  localparam int SBC_BIT_LOST  = 2;
  localparam int SBC_BIT_ACK   = 1;
  localparam int SBC_BIT_INT   = 0;

  // Bus timing: half a bit time expressed in link-clock cycles, rounded up.
  localparam int SBC_LINK_PERIOD_NS = 80;
  localparam int SBC_HALF_BIT_NS    = 1250;
  localparam int SBC_HALF_TICKS     = (SBC_HALF_BIT_NS + SBC_LINK_PERIOD_NS - 1)
                                      / SBC_LINK_PERIOD_NS;

  // Bit counter values for the acknowledge slot and its end.
  localparam logic [3:0] SBC_ACK_SLOT = 4'h8;
  localparam logic [3:0] SBC_ACK_DONE = 4'h9;

  // Link engine phases.
  typedef enum logic [2:0] {
    SBC_IDLE      = 3'b000,
    SBC_GEN_START = 3'b001,
    SBC_XFER      = 3'b010,
    SBC_STALL     = 3'b011,
    SBC_GEN_STOP  = 3'b100
  } sbc_phase_t;

  // Control/status register layout, bit 7 first.
  typedef struct packed {
    logic role;
    logic txInd;
    logic beginCond;
    logic haltCond;
    logic respReq;
    logic contLost;
    logic ackBit;
    logic intFlag;
  } sbc_status_t;

  // Special-function register port request.
  typedef struct packed {
    logic       wr;
    logic       bitWr;
    logic [7:0] addr;
    logic [7:0] page;
    logic [7:0] wdata;
    logic [2:0] bitSel;
    logic       bitVal;
  } sbc_sfr_req_t;

  // Command from the register side to the link engine.
  typedef struct packed {
    logic       doBegin;
    logic       doHalt;
    logic       ackOut;
    logic       transmitter_indicator;
    logic [7:0] data;
  } sbc_cmd_t;

  // Event flags from the link engine.
  typedef struct packed {
    logic startGen;
    logic stopGen;
    logic startSeen;
    logic stopSeen;
    logic addrRx;
    logic byteRx;
    logic byteTx;
    logic ackDone;
    logic contention_lost_flag;
    logic arbStop;
  } sbc_evt_flags_t;

  typedef struct packed {
    sbc_evt_flags_t flags;
    logic           ackIn;
    logic [7:0]     rxData;
  } sbc_evt_t;

endpackage

/* File: src/sbc_link.sv */
// Purpose: Bit-level two-wire engine running on the link clock.
// Assumes: Pins are open drain; commands and events cross by toggle handshake.
// Notes: Command and event payloads stay stable while their toggle settles.
`timescale 1ns/1ps
`default_nettype none
module sbc_link
  import sbc_pkg::*;
#(
  parameter int HALF_TICKS = sbc_pkg::SBC_HALF_TICKS
)(
  // Link clock and reset.
  input  wire logic              linkClk,
  input  wire logic              rst_b,
  // Commands and stall level from the register side.
  input  wire logic              cmdTgl,
  input  wire sbc_pkg::sbc_cmd_t cmd,
  input  wire logic              siFlag,
  // Events toward the register side.
  output logic                   evtTgl,
  output sbc_pkg::sbc_evt_t      evt,
  // Bus pins.
  input  wire logic              sclIn,
  input  wire logic              sdaIn,
  output logic                   sclOut,
  output logic                   sclOutEn_b,
  output logic                   sdaOut,
  output logic                   sdaOutEn_b
);
  import sbc_pkg::*;

  typedef struct packed {
    logic [1:0] sclSy;
    logic [1:0] sdaSy;
    logic [1:0] siSy;
    logic [2:0] cmdSy;
    logic       sclPrev;
    logic       sdaPrev;
    sbc_phase_t phase;
    logic [1:0] step;
    logic [7:0] tick;
    logic       master;
    logic       addressed;
    logic       inhibit;
    logic       addrPhase;
    logic       transmitter_indicator;
    logic       pendStart;
    logic       pendStop;
    logic       ackOut;
    logic       ackIn;
    logic       nxtTx;
    logic [7:0] nxtData;
    logic [7:0] shift;
    logic [3:0] bitCnt;
    logic       sclDrv;
    logic       sdaDrv;
    logic       sclEn_b;
    logic       sdaEn_b;
    logic       evtTgl;
    sbc_evt_t   evt;
  } sbc_link_state_t;

  sbc_link_state_t q;
  sbc_link_state_t n;
  sbc_evt_t        ev;
  logic            arb;
  logic            sclH;
  logic            sdaH;
  logic            sclRise;
  logic            sclFall;
  logic            startDet;
  logic            stopDet;
  logic            tickHit;

  // Next-state logic of the whole engine.
  always_comb
  begin
    n = q;
    ev = '0;
    arb = 1'b0;
    sclH = q.sclSy[1];
    sdaH = q.sdaSy[1];
    n.sclSy = {q.sclSy[0], sclIn};
    n.sdaSy = {q.sdaSy[0], sdaIn};
    n.siSy = {q.siSy[0], siFlag};
    n.cmdSy = {q.cmdSy[1], q.cmdSy[0], cmdTgl};
    n.sclPrev = sclH;
    n.sdaPrev = sdaH;
    sclRise = sclH & ~q.sclPrev;
    sclFall = ~sclH & q.sclPrev;
    startDet = sclH & q.sclPrev & q.sdaPrev & ~sdaH;
    stopDet = sclH & q.sclPrev & ~q.sdaPrev & sdaH;
    tickHit = (q.tick == 8'(HALF_TICKS - 1));
    n.tick = tickHit ? 8'h00 : q.tick + 8'h01;
    unique case (q.phase)
      SBC_IDLE:
        if (q.pendStart & ~q.siSy[1])
        begin
          n.phase = SBC_GEN_START;
          n.step = 2'h0;
        end
      SBC_GEN_START:
        if (tickHit)
        begin
          unique case (q.step)
            2'h0:
            begin
              n.sclDrv = 1'b0;
              n.sdaDrv = 1'b0;
              n.step = 2'h1;
            end
            2'h1:
              if (sclH & sdaH)
                n.step = 2'h2;
              else if (q.master & ~sclH)
                arb = 1'b1;
            2'h2:
            begin
              n.sdaDrv = 1'b1;
              n.step = 2'h3;
            end
            2'h3:
            begin
              n.sclDrv = 1'b1;
              n.master = 1'b1;
              n.pendStart = 1'b0;
              n.transmitter_indicator = 1'b1;
              n.bitCnt = 4'h0;
              ev.flags.startGen = 1'b1;
              n.phase = SBC_STALL;
            end
          endcase
        end
      SBC_GEN_STOP:
        if (tickHit)
        begin
          unique case (q.step)
            2'h0:
            begin
              n.sdaDrv = 1'b1;
              n.sclDrv = 1'b1;
              n.step = 2'h1;
            end
            2'h1:
            begin
              n.sclDrv = 1'b0;
              n.step = 2'h2;
            end
            2'h2:
              if (~sclH)
                arb = 1'b1;
              else
              begin
                n.sdaDrv = 1'b0;
                n.step = 2'h3;
              end
            2'h3:
            begin
              ev.flags.stopGen = 1'b1;
              n.master = 1'b0;
              n.pendStop = 1'b0;
              n.step = 2'h0;
              n.phase = q.pendStart ? SBC_GEN_START : SBC_IDLE;
            end
          endcase
        end
      SBC_XFER:
      begin
        if (q.master & tickHit)
        begin
          if (q.sclDrv)
            n.sclDrv = 1'b0;
          else if (sclH)
            n.sclDrv = 1'b1;
        end
        if (sclRise)
        begin
          n.bitCnt = q.bitCnt + 4'h1;
          if (q.bitCnt < SBC_ACK_SLOT)
          begin
            n.shift = {q.shift[6:0], sdaH};
            if (q.transmitter_indicator & ~q.sdaDrv & ~sdaH)
              arb = 1'b1;
          end
          else
            n.ackIn = ~sdaH;
        end
        if (sclFall)
        begin
          n.sdaDrv = 1'b0;
          if (q.bitCnt < SBC_ACK_SLOT)
            n.sdaDrv = q.transmitter_indicator & ~q.shift[7];
          else if (q.bitCnt == SBC_ACK_SLOT)
          begin
            if (~q.transmitter_indicator & q.inhibit & ~q.master)
              n.phase = SBC_IDLE;
            else if (~q.transmitter_indicator)
            begin
              ev.flags.addrRx = q.addrPhase;
              ev.flags.byteRx = ~q.addrPhase;
              n.phase = SBC_STALL;
            end
          end
          else
          begin
            ev.flags.ackDone = 1'b1;
            n.addrPhase = 1'b0;
            if (q.addrPhase)
            begin
              n.addressed = q.ackOut;
              n.inhibit = ~q.ackOut;
            end
            if (q.addrPhase & ~q.ackOut)
              n.phase = SBC_IDLE;
            else if (q.transmitter_indicator)
            begin
              ev.flags.byteTx = 1'b1;
              n.phase = SBC_STALL;
            end
            else if (q.master & q.pendStop)
            begin
              n.phase = SBC_GEN_STOP;
              n.step = 2'h0;
            end
            else if (q.master & q.pendStart)
            begin
              n.phase = SBC_GEN_START;
              n.step = 2'h0;
            end
            else
            begin
              n.bitCnt = 4'h0;
              n.transmitter_indicator = q.nxtTx;
              n.shift = q.nxtData;
              n.sdaDrv = q.nxtTx & ~q.nxtData[7];
            end
          end
        end
      end
      SBC_STALL:
        n.sclDrv = 1'b1;
      default:
        n.phase = SBC_IDLE;
    endcase
    // Bus condition monitor, muted while this end makes its own conditions.
    if ((q.phase != SBC_GEN_START) && (q.phase != SBC_GEN_STOP))
    begin
      if (startDet)
      begin
        if (q.master & ~q.pendStart)
          arb = 1'b1;
        else
        begin
          ev.flags.startSeen = 1'b1;
          n.phase = SBC_XFER;
          n.bitCnt = 4'h0;
          n.transmitter_indicator = 1'b0;
          n.addrPhase = 1'b1;
          n.inhibit = 1'b0;
          n.addressed = 1'b0;
          n.sdaDrv = 1'b0;
          n.sclDrv = 1'b0;
        end
      end
      else if (stopDet)
      begin
        // stop seen as master or slave
        if (q.master)
        begin
          arb = 1'b1;
          ev.flags.arbStop = 1'b1;
        end
        else
        begin
          ev.flags.stopSeen = q.addressed;
          n.addressed = 1'b0;
          n.addrPhase = 1'b0;
          n.phase = SBC_IDLE;
        end
      end
    end
    // Commands arrive only after the register side has released its stall.
    if (q.cmdSy[2] ^ q.cmdSy[1])
    begin
      n.pendStart = q.pendStart | cmd.doBegin;
      n.pendStop = q.pendStop | (cmd.doHalt & q.master);
      n.ackOut = cmd.ackOut;
      n.nxtTx = cmd.transmitter_indicator;
      n.nxtData = cmd.data;
      if (q.phase == SBC_STALL)
      begin
        n.phase = SBC_XFER;
        n.step = 2'h0;
        // A master keeps the clock low until the next tick so data settles first.
        if (q.bitCnt == SBC_ACK_SLOT)
        begin
          n.sdaDrv = cmd.ackOut;
          n.sclDrv = q.master;
        end
        else if (q.master & cmd.doHalt)
          n.phase = SBC_GEN_STOP;
        else if (q.master & cmd.doBegin)
          n.phase = SBC_GEN_START;
        else
        begin
          n.bitCnt = 4'h0;
          n.shift = cmd.data;
          n.transmitter_indicator = cmd.transmitter_indicator;
          n.sdaDrv = cmd.transmitter_indicator & ~cmd.data[7];
          n.sclDrv = q.master;
        end
      end
    end
    // Lost arbitration drops every drive and returns to listening.
    if (arb)
    begin
      ev.flags.contention_lost_flag = 1'b1;
      n.master = 1'b0;
      n.transmitter_indicator = 1'b0;
      n.sdaDrv = 1'b0;
      n.sclDrv = 1'b0;
      n.pendStop = 1'b0;
      n.phase = SBC_IDLE;
    end
    ev.ackIn = n.ackIn;
    ev.rxData = q.shift;
    if (|ev.flags)
    begin
      n.evt = ev;
      n.evtTgl = ~q.evtTgl;
    end
    // clock held low while interrupt pending
    n.sclEn_b = ~(n.sclDrv | q.siSy[1]);
    n.sdaEn_b = ~n.sdaDrv;
  end

  // State register.
  always_ff @(posedge linkClk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.sclSy <= 2'h3;
      q.sdaSy <= 2'h3;
      q.sclPrev <= 1'b1;
      q.sdaPrev <= 1'b1;
      q.sclEn_b <= 1'b1;
      q.sdaEn_b <= 1'b1;
    end
    else
      q <= n;
  end

  // Open-drain pins drive low only, so the level output is a constant zero.
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOutEn_b = q.sclEn_b;
  assign sdaOutEn_b = q.sdaEn_b;
  assign evtTgl = q.evtTgl;
  assign evt = q.evt;

endmodule // sbc_link
`default_nettype wire

/* File: src/sbc_ctrl.sv */
// Purpose: Control/status register and byte-level sequencing of the serial bus.
// Assumes: SFR port is synchronous to mclk; the link engine runs on linkClk.
// Notes: Read data is registered, one mclk after the address is presented.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Role bit set on start, cleared otherwise.
// - Transmitter bit follows start and data writes.
// - Begin flag set on received start plus address.
// - Writing begin one requests start or restart.
// - Halt one sends stop after acknowledge, self-clears.
// - Halt set on slave stop or stop-loss.
// - Response request set per received byte.
// - Unrequested repeated start as master loses contention.
// - Clock low during stop or restart loses.
// - Data low while sending one loses.
// - Contention flag clears when interrupt clears.
// - Acknowledge bit holds received or outgoing value.
// - Interrupt flag set on listed bus events.
// - Pending interrupt holds clock low, stalls bus.
// - Clearing interrupt advances; writing one forces.
// - Register at 0xC0 page 0, resets zero.
// - Begin flag stays set after generated start.
// - Begin and halt together: stop, then start.
// - Unwritten acknowledge before clearing sends negative.
// - Declined address ignores slave events until start.
module sbc_ctrl
  import sbc_pkg::*;
#(
  parameter int HALF_TICKS = sbc_pkg::SBC_HALF_TICKS
)(
  // Clocks and reset.
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  input  wire logic                  linkClk,
  // Special-function register port.
  input  wire sbc_pkg::sbc_sfr_req_t sfrReq,
  output logic [7:0]                 sfrRdata,
  // Two-wire bus pins.
  input  wire logic                  sclIn,
  input  wire logic                  sdaIn,
  output logic                       sclOut,
  output logic                       sclOutEn_b,
  output logic                       sdaOut,
  output logic                       sdaOutEn_b
);
  import sbc_pkg::*;

  typedef struct packed {
    sbc_status_t status;
    logic [7:0]  data;
    logic [7:0]  rdata;
    logic        ackWritten;
    logic        dataWritten;
    sbc_cmd_t    cmd;
    logic        cmdTgl;
    logic        evtS1;
    logic        evtS2;
    logic        evtSeen;
  } sbc_ctrl_state_t;

  sbc_ctrl_state_t q;
  sbc_ctrl_state_t n;
  sbc_evt_t        linkEvt;
  logic            linkEvtTgl;
  logic            selCtrl;
  logic            selData;
  logic [7:0]      wrMask;
  logic [7:0]      wrVal;
  logic            siClear;
  logic            startReq;
  logic            dataWr;
  logic            ackNow;
  logic            evtNew;

  // Bit-level engine on the link clock.
  sbc_link #(
    .HALF_TICKS (HALF_TICKS)
  ) u_link (
    .linkClk    (linkClk),
    .rst_b      (rst_b),
    .cmdTgl     (q.cmdTgl),
    .cmd        (q.cmd),
    .siFlag     (q.status.intFlag),
    .evtTgl     (linkEvtTgl),
    .evt        (linkEvt),
    .sclIn      (sclIn),
    .sdaIn      (sdaIn),
    .sclOut     (sclOut),
    .sclOutEn_b (sclOutEn_b),
    .sdaOut     (sdaOut),
    .sdaOutEn_b (sdaOutEn_b)
  );

  // Address decode of the two registers.
  always_comb
  begin
    selCtrl = (sfrReq.addr == SBC_CTRL_ADDR) && (sfrReq.page == SBC_SFR_PAGE);
    selData = (sfrReq.addr == SBC_DATA_ADDR) && (sfrReq.page == SBC_SFR_PAGE);
    dataWr = sfrReq.wr & selData;
  end

  // Byte and single-bit writes reduce to one mask and one value.
  always_comb
  begin
    wrMask = 8'h00;
    wrVal = 8'h00;
    if (sfrReq.wr && selCtrl)
    begin
      wrMask = SBC_CTRL_WMASK;
      wrVal = sfrReq.wdata;
    end
    else if (sfrReq.bitWr && selCtrl)
    begin
      wrMask = SBC_CTRL_WMASK & (8'h01 << sfrReq.bitSel);
      wrVal = {8{sfrReq.bitVal}};
    end
    siClear = wrMask[SBC_BIT_INT] & ~wrVal[SBC_BIT_INT] & q.status.intFlag;
    startReq = wrMask[SBC_BIT_BEGIN] & wrVal[SBC_BIT_BEGIN]
               & ~q.status.intFlag & ~q.status.role;
    ackNow = wrMask[SBC_BIT_ACK];
    evtNew = q.evtS2 ^ q.evtSeen;
  end

  // Next state: software effects first, hardware events after so that they win.
  always_comb
  begin
    n = q;
    // Event toggle crossing from the link clock.
    n.evtS1 = linkEvtTgl;
    n.evtS2 = q.evtS1;
    n.evtSeen = q.evtS2;
    // Software writes to the writable bits.
    if (wrMask[SBC_BIT_BEGIN])
      n.status.beginCond = wrVal[SBC_BIT_BEGIN];
    if (wrMask[SBC_BIT_HALT])
      n.status.haltCond = wrVal[SBC_BIT_HALT];
    if (ackNow)
    begin
      n.status.ackBit = wrVal[SBC_BIT_ACK];
      n.ackWritten = 1'b1;
    end
    if (wrMask[SBC_BIT_INT])
      n.status.intFlag = wrVal[SBC_BIT_INT];
    if (dataWr)
    begin
      n.data = sfrReq.wdata;
      n.dataWritten = 1'b1;
    end
    // Clearing the interrupt releases the engine with a fresh command.
    if (siClear | startReq)
    begin
      n.cmd.doBegin = n.status.beginCond;
      n.cmd.doHalt = n.status.haltCond;
      n.cmd.ackOut = (q.ackWritten | ackNow) & n.status.ackBit;
      n.cmd.transmitter_indicator = q.dataWritten | dataWr;
      n.cmd.data = n.data;
      n.cmdTgl = ~q.cmdTgl;
    end
    if (siClear)
    begin
      n.status.txInd = q.dataWritten | dataWr;
      n.status.contLost = 1'b0;
      n.ackWritten = 1'b0;
      n.dataWritten = 1'b0;
    end
    // Hardware events from the link engine.
    if (evtNew)
    begin
      if (linkEvt.flags.startGen)
      begin
        n.status.role = 1'b1;
        n.status.txInd = 1'b1;
        n.status.intFlag = 1'b1;
      end
      // halt clears once stop is out
      if (linkEvt.flags.stopGen)
      begin
        n.status.role = 1'b0;
        n.status.haltCond = 1'b0;
      end
      if (linkEvt.flags.startSeen)
        n.status.txInd = 1'b0;
      if (linkEvt.flags.stopSeen)
      begin
        n.status.haltCond = 1'b1;
        n.status.intFlag = 1'b1;
      end
      if (linkEvt.flags.addrRx)
        n.status.beginCond = 1'b1;
      if (linkEvt.flags.addrRx | linkEvt.flags.byteRx)
      begin
        n.status.respReq = 1'b1;
        n.status.intFlag = 1'b1;
        n.data = linkEvt.rxData;
      end
      if (linkEvt.flags.byteTx)
      begin
        n.status.ackBit = linkEvt.ackIn;
        n.status.intFlag = 1'b1;
        n.data = linkEvt.rxData;
      end
      if (linkEvt.flags.ackDone)
        n.status.respReq = 1'b0;
      if (linkEvt.flags.contention_lost_flag)
      begin
        n.status.contLost = 1'b1;
        n.status.role = 1'b0;
        n.status.txInd = 1'b0;
        n.status.intFlag = 1'b1;
        if (linkEvt.flags.arbStop)
          n.status.haltCond = 1'b1;
      end
    end
    // Registered read data; unmapped addresses read zero.
    if (selCtrl)
      n.rdata = q.status;
    else if (selData)
      n.rdata = q.data;
    else
      n.rdata = 8'h00;
  end

  // State register.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.status <= sbc_status_t'(SBC_CTRL_RESET);
      q.data <= SBC_DATA_RESET;
    end
    else
      q <= n;
  end

  assign sfrRdata = q.rdata;

endmodule // sbc_ctrl
`default_nettype wire

/* File: verif/sbc_ctrl_asserts.sv */
// Purpose: Concurrent checks on the serial bus control block's ports.
// Assumes: Status reads are valid one mclk after address 0xC0 is presented.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module sbc_ctrl_asserts
  import sbc_pkg::*;
(
  // Clocks and reset.
  input wire logic                  mclk,
  input wire logic                  rst_b,
  input wire logic                  linkClk,
  // Register port.
  input wire sbc_pkg::sbc_sfr_req_t sfrReq,
  input wire logic [7:0]            sfrRdata,
  // Pin enables.
  input wire logic                  sclOutEn_b,
  input wire logic                  sdaOutEn_b
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // Address decode, read validity and cycles with the interrupt seen set.
  wire logic  isC0 = sfrReq.addr == SBC_CTRL_ADDR && sfrReq.page == SBC_SFR_PAGE;
  logic       rdC0_q;
  logic [4:0] siCnt_q;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdC0_q  <= 1'b0;
      siCnt_q <= 5'h00;
    end
    else
    begin
      rdC0_q  <= isC0;
      siCnt_q <= !(rdC0_q && sfrRdata[0]) ? 5'h00 : siCnt_q + 5'(siCnt_q != 5'h1F);
    end
  end

  // Register values, stickiness and pin effects.
  property p_rst_zero;
    !$past(rst_b) |-> sfrRdata == 8'h00;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("read not zero after reset");
  property p_force_int;
    sfrReq.wr && isC0 && sfrReq.wdata[0] ##1 isC0 |=> sfrRdata[0];
  endproperty
  a_force_int: assert property (p_force_int) else $error("forced interrupt lost");
  property p_int_sticky;
    rdC0_q && isC0 && sfrRdata[0] && !$past(sfrReq.wr || sfrReq.bitWr) |=> sfrRdata[0];
  endproperty
  a_int_sticky: assert property (p_int_sticky) else $error("interrupt cleared alone");
  property p_begin_sticky;
    rdC0_q && isC0 && sfrRdata[5] && !$past(sfrReq.wr || sfrReq.bitWr) |=> sfrRdata[5];
  endproperty
  a_begin_sticky: assert property (p_begin_sticky) else $error("begin cleared alone");
  property p_ack_wr;
    sfrReq.wr && isC0 ##1 isC0 |=> sfrRdata[1] == $past(sfrReq.wdata[1], 2);
  endproperty
  a_ack_wr: assert property (p_ack_wr) else $error("ack write not held");
  property p_lost_clr;
    sfrReq.wr && isC0 && !sfrReq.wdata[0] ##1 isC0 |=> !sfrRdata[2];
  endproperty
  a_lost_clr: assert property (p_lost_clr) else $error("lost flag kept");
  property p_scl_hold;
    siCnt_q == 5'h1F |-> !sclOutEn_b;
  endproperty
  a_scl_hold: assert property (p_scl_hold) else $error("clock free while pending");
  property p_start_drv;
    sfrReq.wr && isC0 && sfrReq.wdata == 8'h20 |-> ##[1:400] !sdaOutEn_b;
  endproperty
  a_start_drv: assert property (p_start_drv) else $error("no start driven");
endmodule // sbc_ctrl_asserts

bind sbc_ctrl sbc_ctrl_asserts u_chk (.mclk(mclk), .rst_b(rst_b), .linkClk(linkClk),
  .sfrReq(sfrReq), .sfrRdata(sfrRdata), .sclOutEn_b(sclOutEn_b), .sdaOutEn_b(sdaOutEn_b));
`default_nettype wire

/* File: verif/sbc_slave_model.sv */
// Purpose: Behavioural bus target that takes written bytes.
// Assumes: Wires are pulled up; the model only pulls data low.
// Notes: Acknowledges each byte while ackEn is high.
`timescale 1ns/1ps
`default_nettype none
module sbc_slave_model (
  // Bus wires.
  input  wire logic  scl,
  input  wire logic  sda,
  output logic       sdaPull_b,
  // Control and capture.
  input  wire logic  ackEn,
  output logic [7:0] rxByte
);
  int         bitCnt = 0;
  int         starts = 0;
  int         startsSeen = 0;
  logic [7:0] shReg = 8'h00;
  logic [7:0] rxCap = 8'h00;
  logic       pullLow = 1'b0;
  assign sdaPull_b = !pullLow;
  assign rxByte = rxCap;
  // A start condition is counted; the next rising clock restarts byte framing.
  always @(negedge sda)
    if (scl)
      starts++;
  // Data is sampled on the rising clock, first bit into the top.
  always @(posedge scl)
  begin
    if (starts != startsSeen)
    begin
      bitCnt = 0;
      startsSeen = starts;
    end
    if (bitCnt < 8)
      shReg = {shReg[6:0], sda};
    bitCnt = (bitCnt == 8) ? 0 : bitCnt + 1;
    if (bitCnt == 8)
      rxCap = shReg;
  end
  // Data is pulled low through the acknowledge slot only.
  always @(negedge scl)
    pullLow = (bitCnt == 8) && ackEn && (starts == startsSeen);
endmodule // sbc_slave_model
`default_nettype wire

/* File: verif/sbc_ctrl_tb.sv */
// Purpose: Self-checking bench for the serial bus control block.
// Assumes: One target model on pulled-up wires; inputs change on falling mclk.
// Notes: HALF_TICKS is cut to 4 to keep bytes short.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %0t: got %h expected %h", $time, (g), (e)); end end
module sbc_ctrl_tb;
  import sbc_pkg::*;
  localparam logic [7:0] CA = SBC_CTRL_ADDR;
  localparam logic [7:0] DA = SBC_DATA_ADDR;
  logic         mclk = 1'b0;
  logic         linkClk = 1'b0;
  logic         rst_b = 1'b0;
  logic         ackEn = 1'b1;
  sbc_sfr_req_t sfrReq = '0;
  logic [7:0]   sfrRdata, rxByte, rd;
  logic         sclOut, sclOutEn_b, sdaOut, sdaOutEn_b, sdaPull_b;
  int           failures = 0;
  int           samples_checked = 0;
  int           cycles = 0;
  // Open-drain wires with pull-ups.
  wire logic    sclW = sclOutEn_b ? 1'b1 : sclOut;
  wire logic    sdaW = (sdaOutEn_b ? 1'b1 : sdaOut) & sdaPull_b;

  // System clock, and a link clock of unrelated phase.
  always #12.5 mclk = !mclk;
  initial
  begin
    #7;
    forever #40 linkClk = !linkClk;
  end

  sbc_ctrl #(.HALF_TICKS(4)) dut (.mclk(mclk), .rst_b(rst_b), .linkClk(linkClk),
    .sfrReq(sfrReq), .sfrRdata(sfrRdata), .sclIn(sclW), .sdaIn(sdaW), .sclOut(sclOut),
    .sclOutEn_b(sclOutEn_b), .sdaOut(sdaOut), .sdaOutEn_b(sdaOutEn_b));
  sbc_slave_model slv (.scl(sclW), .sda(sdaW), .sdaPull_b(sdaPull_b), .ackEn(ackEn),
    .rxByte(rxByte));

  // One request: byte write, or bit write of d[7] to bit d[2:0] when bw is set.
  task automatic put(input logic [7:0] a, d, pg = 8'h00, input logic bw = 1'b0);
    @(negedge mclk);
    sfrReq = '{!bw, bw, a, pg, d, d[2:0], d[7]};
    @(negedge mclk);
    sfrReq = '{1'b0, 1'b0, CA, 8'h00, d, d[2:0], d[7]};
  endtask
  // Registered read of one address.
  task automatic get(input logic [7:0] a);
    @(negedge mclk);
    sfrReq.addr = a;
    @(negedge mclk);
    rd = sfrRdata;
  endtask
  // Poll status until bit b reads v, with a bounded count.
  task automatic waitBit(input int b, input logic v);
    int n;
    n = 0;
    get(CA);
    while (rd[b] !== v && n < 3000)
    begin
      get(CA);
      n++;
    end
  endtask

  // Reset values, unmapped and read-only places, forced interrupt.
  task automatic t_regs();
    get(CA);
    `CHK(rd, SBC_CTRL_RESET)
    get(8'hC4);
    `CHK(rd, 8'h00)
    put(CA, 8'hCC);
    put(CA, 8'h87, 8'h00, 1'b1);
    put(CA, 8'h01, 8'h01);
    get(CA);
    `CHK(rd, 8'h00)
    put(CA, 8'h01);
    repeat (40) @(negedge mclk);
    get(CA);
    `CHK(rd, 8'h01)
    `CHK(sclW, 1'b0)
    put(CA, 8'h00, 8'h00, 1'b1);
    get(CA);
    `CHK(rd, 8'h00)
  endtask

  // Master write: start, acknowledged address byte, refused data byte, stop.
  task automatic t_write();
    put(CA, 8'h20);
    waitBit(0, 1'b1);
    `CHK(rd, 8'hE1)
    `CHK(sclW, 1'b0)
    put(DA, 8'hA4);
    put(CA, 8'h00);
    waitBit(0, 1'b1);
    `CHK(rd, 8'hC3)
    `CHK(rxByte, 8'hA4)
    ackEn = 1'b0;
    put(DA, 8'h5B);
    put(CA, 8'h00);
    waitBit(0, 1'b1);
    `CHK(rd, 8'hC1)
    `CHK(rxByte, 8'h5B)
    ackEn = 1'b1;
    put(CA, 8'h10);
    waitBit(7, 1'b0);
    `CHK({rd[7], rd[4], rd[0]}, 3'h0)
    `CHK({sclW, sdaW}, 2'h3)
  endtask

  // Verdict and end of run.
  task automatic test_done();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      test_done();
    end
  end

  // Main sequence.
  initial
  begin
    repeat (4) @(negedge mclk);
    rst_b = 1'b1;
    t_regs();
    t_write();
    test_done();
  end
endmodule // sbc_ctrl_tb
`default_nettype wire
